/* core/flash_command_sequencer.sv */
// Flash command sequencer: decodes unlock-coded write sequences into program,
// erase, identification and security operations, and reports progress on reads.
// Assumes a CPU bus on the same clock, one read or write strobe per cycle, and a
// flash array that reads combinationally and erases to all ones on its pulses.
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_cfg.svh"

module flash_command_sequencer import flash_seq_pkg::*; #(
    parameter int unsigned PROG_CYCLES  = `FCS_PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = `FCS_ERASE_CYCLES,
    // Arbitrary identification values
    parameter logic [7:0]  MAKER_CODE   = 8'h3c,
    parameter logic [7:0]  FLASH_CODE   = 8'h5a
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // CPU bus
    input  wire logic        BUS_WR,
    input  wire logic        BUS_RD,
    input  wire logic [15:0] BUS_ADDR,
    input  wire logic [7:0]  BUS_WDATA,
    output logic      [7:0]  BUS_RDATA,
    output logic             BUS_RVALID,
    // Control register fields
    input  wire logic [2:0]  COMMAND_ENABLE_FIELD,
    input  wire logic        CONTROL_COMMIT_WR,
    input  wire logic [7:0]  CONTROL_COMMIT_KEY,
    // Operating mode pins
    input  wire logic        PARALLEL_MODE,
    input  wire logic        SERIAL_MODE,
    // Stored security state
    input  wire logic        SECURITY_STORED,
    // Flash array
    output logic      [14:0] ARR_ADDR,
    output logic      [7:0]  ARR_WDATA,
    output logic             ARR_WE,
    output logic             ARR_RE,
    input  wire logic [7:0]  ARR_RDATA,
    output logic             ARR_SECTOR_ERASE,
    output logic      [2:0]  ARR_SECTOR,
    output logic             ARR_CHIP_ERASE,
    // Status
    output logic             BUSY,
    output logic             ID_MODE,
    output logic             CMD_ENABLED,
    output logic             SECURITY_ACTIVE,
    output logic             PARALLEL_LOCK,
    output logic             SERIAL_CMD_LOCK
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    localparam int unsigned TW = `FCS_TIMER_W;

    if (PROG_CYCLES == 0 || PROG_CYCLES >= (1 << TW)) begin : g_bad_prog
        $error("PROG_CYCLES out of range");
    end
    if (ERASE_CYCLES == 0 || ERASE_CYCLES >= (1 << TW)) begin : g_bad_erase
        $error("ERASE_CYCLES out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic hit(input logic [15:0] addr, input logic [7:0] data,
                                 input logic [11:0] exp_addr, input logic [7:0] exp_data);
        hit = (addr[11:0] == exp_addr) && (data == exp_data);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////
    // Mode pin synchronisers

    logic [1:0] par_s_q;
    logic [1:0] ser_s_q;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            par_s_q <= 2'h0;
            ser_s_q <= 2'h0;
        end else begin
            par_s_q <= {par_s_q[0], PARALLEL_MODE};
            ser_s_q <= {ser_s_q[0], SERIAL_MODE};
        end
    end

    wire par_mode = par_s_q[1];
    wire ser_mode = ser_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // State

    seq_state_t state_q;
    seq_state_t state_d;
    op_kind_t   op_q;
    op_kind_t   op_d;
    logic       start_op;
    logic       cmd_en_q;
    logic       busy_q;
    logic       toggle_q;
    logic       id_q;
    logic       sec_q;
    logic       sec_loaded_q;
    logic       op_done;
    logic       timer_running;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    wire        in_window  = BUS_ADDR[`FCS_WINDOW_BIT];
    wire        par_lock   = sec_q && par_mode;
    wire        wr_take    = BUS_WR && !BUS_RD && in_window && cmd_en_q
                             && !busy_q && !par_lock;
    wire        rd_take    = BUS_RD && in_window;
    wire        hit_unl_a  = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_A, `FCS_UNLOCK_DATA_A);
    wire        hit_unl_b  = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_B, `FCS_UNLOCK_DATA_B);
    wire        hit_prog   = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_A, `FCS_CMD_PROGRAM);
    wire        hit_esetup = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_A, `FCS_CMD_ERASE_SETUP);
    wire        hit_idin   = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_A, `FCS_CMD_ID_ENTRY);
    wire        hit_secure = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_A, `FCS_CMD_SECURITY);
    wire        hit_chip   = hit(BUS_ADDR, BUS_WDATA, `FCS_UNLOCK_ADDR_A, `FCS_CMD_CHIP);
    wire        hit_sector = (BUS_WDATA == `FCS_CMD_SECTOR);
    wire        hit_secdat = (BUS_ADDR == `FCS_ID_SEC_ADDR) && (BUS_WDATA == `FCS_SECURITY_DATA);
    wire        id_enter   = wr_take && (state_q == ST_UNL2) && hit_idin;
    wire        id_exit    = wr_take && (state_q != ST_PROG)
                             && (BUS_WDATA == `FCS_CMD_ID_EXIT);
    wire        commit     = CONTROL_COMMIT_WR && (CONTROL_COMMIT_KEY == `FCS_COMMIT_KEY);

    ////////////////////////////////////////////////////////////////////////////
    // Sequence decoder

    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        start_op = 1'b0;
        if (wr_take) begin
            unique case (state_q)
                ST_IDLE: state_d = hit_unl_a ? ST_UNL1 : ST_IDLE;
                ST_UNL1: state_d = hit_unl_b ? ST_UNL2 : ST_IDLE;
                ST_UNL2: begin
                    if (hit_prog) begin
                        state_d = ST_PROG;
                    end else if (hit_esetup) begin
                        state_d = ST_ER3;
                    end else if (hit_secure) begin
                        state_d = ST_SEC;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
                ST_ER3: state_d = hit_unl_a ? ST_ER4 : ST_IDLE;
                ST_ER4: state_d = hit_unl_b ? ST_ER5 : ST_IDLE;
                ST_ER5: begin
                    state_d = ST_IDLE;
                    if (hit_sector && !par_mode) begin
                        op_d     = OP_SECTOR;
                        start_op = 1'b1;
                    end else if (hit_chip) begin
                        op_d     = OP_CHIP;
                        start_op = 1'b1;
                    end
                end
                ST_PROG: begin
                    state_d  = ST_IDLE;
                    op_d     = OP_PROG;
                    start_op = 1'b1;
                end
                ST_SEC: begin
                    state_d = ST_IDLE;
                    if (hit_secdat) begin
                        op_d     = OP_SECURE;
                        start_op = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            op_q    <= OP_PROG;
        end else begin
            state_q <= state_d;
            op_q    <= op_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command enable and identification mode

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cmd_en_q <= `FCS_CMD_EN_RESET;
        end else if (commit && COMMAND_ENABLE_FIELD == `FCS_MODE_ENABLE) begin
            cmd_en_q <= 1'b1;
        end else if (commit && COMMAND_ENABLE_FIELD == `FCS_MODE_DISABLE) begin
            cmd_en_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            id_q <= 1'b0;
        end else if (id_enter) begin
            id_q <= 1'b1;
        end else if (id_exit) begin
            id_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation timing

    wire [TW-1:0] prog_len  = TW'(PROG_CYCLES);
    wire [TW-1:0] erase_len = TW'(ERASE_CYCLES);
    wire          long_op   = (op_d == OP_SECTOR) || (op_d == OP_CHIP);
    wire [TW-1:0] op_len    = long_op ? erase_len : prog_len;

    flash_op_timer #(
        .W       (TW)
    ) u_timer (
        .clk     (CLK_SYS),
        .rst     (RST),
        .start   (start_op),
        .load    (op_len),
        .done    (op_done),
        .running (timer_running)
    );

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            busy_q <= 1'b0;
        end else if (start_op) begin
            busy_q <= 1'b1;
        end else if (op_done) begin
            busy_q <= 1'b0;
        end
    end

    // Toggle inverts per busy read, frozen while commands are disabled
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            toggle_q <= 1'b1;
        end else if (start_op) begin
            toggle_q <= 1'b1;
        end else if (rd_take && busy_q && cmd_en_q) begin
            toggle_q <= ~toggle_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Security state

    // Stored state is caught on the first edge after reset release
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sec_q        <= 1'b0;
            sec_loaded_q <= 1'b0;
        end else if (!sec_loaded_q) begin
            sec_q        <= SECURITY_STORED;
            sec_loaded_q <= 1'b1;
        end else if (op_done && op_q == OP_SECURE) begin
            sec_q        <= 1'b1;
        end else if (op_done && op_q == OP_CHIP) begin
            sec_q        <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    wire [7:0] status_byte = `FCS_STATUS_FILL | (8'(toggle_q) << `FCS_TOGGLE_POS);
    wire [7:0] sec_byte    = sec_q ? `FCS_SEC_ON_VALUE : `FCS_SEC_OFF_VALUE;
    wire       id_maker    = id_q && (BUS_ADDR == `FCS_ID_MAKER_ADDR);
    wire       id_flash    = id_q && (BUS_ADDR == `FCS_ID_FLASH_ADDR);
    wire       id_sec      = id_q && (BUS_ADDR == `FCS_ID_SEC_ADDR);
    wire       rd_const    = par_lock || busy_q || id_maker || id_flash || id_sec;
    wire [7:0] const_byte  = par_lock ? `FCS_BLOCKED_READ :
                             busy_q   ? status_byte :
                             id_maker ? MAKER_CODE :
                             id_flash ? FLASH_CODE :
                                        sec_byte;
    wire       prog_start  = start_op && (op_d == OP_PROG);
    wire       arr_rd      = rd_take && !rd_const;

    logic       rd_pend_q;
    logic       rd_arr_q;
    logic [7:0] rd_const_q;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rd_pend_q  <= 1'b0;
            rd_arr_q   <= 1'b0;
            rd_const_q <= 8'h00;
            BUS_RDATA  <= 8'h00;
            BUS_RVALID <= 1'b0;
        end else begin
            rd_pend_q  <= rd_take;
            rd_arr_q   <= arr_rd;
            rd_const_q <= const_byte;
            BUS_RVALID <= rd_pend_q;
            if (rd_pend_q) begin
                BUS_RDATA <= rd_arr_q ? ARR_RDATA : rd_const_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array commands

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ARR_ADDR         <= 15'h0000;
            ARR_WDATA        <= 8'h00;
            ARR_WE           <= 1'b0;
            ARR_RE           <= 1'b0;
            ARR_SECTOR_ERASE <= 1'b0;
            ARR_SECTOR       <= 3'h0;
            ARR_CHIP_ERASE   <= 1'b0;
        end else begin
            ARR_WE           <= prog_start;
            ARR_RE           <= arr_rd;
            ARR_SECTOR_ERASE <= start_op && (op_d == OP_SECTOR);
            ARR_CHIP_ERASE   <= start_op && (op_d == OP_CHIP);
            if (arr_rd || prog_start) begin
                ARR_ADDR <= BUS_ADDR[14:0];
            end
            if (prog_start) begin
                ARR_WDATA <= BUS_WDATA;
            end
            if (start_op && op_d == OP_SECTOR) begin
                ARR_SECTOR <= BUS_ADDR[`FCS_SECTOR_HI:`FCS_SECTOR_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            BUSY            <= 1'b0;
            ID_MODE         <= 1'b0;
            CMD_ENABLED     <= 1'b0;
            SECURITY_ACTIVE <= 1'b0;
            PARALLEL_LOCK   <= 1'b0;
            SERIAL_CMD_LOCK <= 1'b0;
        end else begin
            BUSY            <= busy_q || start_op;
            ID_MODE         <= id_q;
            CMD_ENABLED     <= cmd_en_q;
            SECURITY_ACTIVE <= sec_q;
            PARALLEL_LOCK   <= par_lock;
            SERIAL_CMD_LOCK <= sec_q && ser_mode;
        end
    end

endmodule : flash_command_sequencer

`default_nettype wire

/* core/flash_op_timer.sv */
// Down counter timing one program, erase or security operation.
// Assumes start is a one-cycle pulse on the same clock; load is at least one.
`timescale 1ns/10ps
`default_nettype none

module flash_op_timer #(
    parameter int unsigned W = 21
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // Status
    output wire logic         done,
    output logic              running
);

    logic [W-1:0] cnt_q;

    // Done in the last cycle of the interval, so busy lasts exactly load cycles
    assign done = running && (cnt_q == '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q   <= '0;
            running <= 1'b0;
        end else if (start) begin
            cnt_q   <= W'(load - 1'b1);
            running <= 1'b1;
        end else if (done) begin
            running <= 1'b0;
        end else if (running) begin
            cnt_q   <= W'(cnt_q - 1'b1);
        end
    end

endmodule : flash_op_timer

`default_nettype wire

/* core/flash_seq_cfg.svh */
// Offsets, command codes, reset values and timing counts of the flash command sequencer.
// Assumes inclusion by bare name from core/ files only.
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

// Unlock and command cycle addresses (low 12 bits only)
`define FCS_UNLOCK_ADDR_A   12'h555
`define FCS_UNLOCK_ADDR_B   12'haaa
// Command data codes
`define FCS_UNLOCK_DATA_A   8'haa
`define FCS_UNLOCK_DATA_B   8'h55
`define FCS_CMD_PROGRAM     8'ha0
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_SECTOR      8'h30
`define FCS_CMD_CHIP        8'h10
`define FCS_CMD_ID_ENTRY    8'h90
`define FCS_CMD_ID_EXIT     8'hf0
`define FCS_CMD_SECURITY    8'ha5
`define FCS_SECURITY_DATA   8'h00
// Identification mode addresses
`define FCS_ID_MAKER_ADDR   16'hf000
`define FCS_ID_FLASH_ADDR   16'hf001
`define FCS_ID_SEC_ADDR     16'hff7f
// Security status read values
`define FCS_SEC_OFF_VALUE   8'hff
`define FCS_SEC_ON_VALUE    8'h00
// Read value while parallel access is locked
`define FCS_BLOCKED_READ    8'h00
// Status byte bits other than the toggle bit
`define FCS_STATUS_FILL     8'hbf
`define FCS_TOGGLE_POS      6
// Window, sector field
`define FCS_WINDOW_BIT      15
`define FCS_SECTOR_HI       14
`define FCS_SECTOR_LO       12
// Command enable field and commit key
`define FCS_MODE_ENABLE     3'b101
`define FCS_MODE_DISABLE    3'b010
`define FCS_COMMIT_KEY      8'hd5
`define FCS_CMD_EN_RESET    1'b0
// Timing
`define FCS_CLK_MHZ         40
`define FCS_PROG_TIME_US    40
`define FCS_ERASE_TIME_MS   30
`define FCS_PROG_CYCLES     (`FCS_PROG_TIME_US * `FCS_CLK_MHZ)
`define FCS_ERASE_CYCLES    (`FCS_ERASE_TIME_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_TIMER_W         21

`endif

/* core/flash_seq_pkg.sv */
// Types of the flash command sequencer.
// Assumes nothing of its surroundings.
package flash_seq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_UNL1 = 3'b001,
        ST_UNL2 = 3'b010,
        ST_ER3  = 3'b011,
        ST_ER4  = 3'b100,
        ST_ER5  = 3'b101,
        ST_PROG = 3'b110,
        ST_SEC  = 3'b111
    } seq_state_t;

    typedef enum logic [1:0] {
        OP_PROG   = 2'b00,
        OP_SECTOR = 2'b01,
        OP_CHIP   = 2'b10,
        OP_SECURE = 2'b11
    } op_kind_t;

endpackage : flash_seq_pkg

/* testbench/flash_array_model.sv */
// Flash array model: byte store that erases to all ones.
// Assumes one-cycle pulses from the sequencer on the same clock.
`timescale 1ns/10ps
`default_nettype none

module flash_array_model (
    // Clock
    input  wire logic        clk,
    // Array side
    input  wire logic        we,
    input  wire logic        re,
    input  wire logic        sec_er,
    input  wire logic        chip_er,
    input  wire logic [2:0]  sector,
    input  wire logic [14:0] addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem [32768];
    initial foreach (mem[i]) mem[i] = 8'hff;
    // Outside read cycles the data is not held
    assign rdata = re ? mem[addr] : ~mem[addr];
    always @(posedge clk) begin
        if (we) mem[addr] <= wdata;
        if (chip_er) foreach (mem[i]) mem[i] <= 8'hff;
        if (sec_er) for (int i = 0; i < 4096; i++) mem[{sector, i[11:0]}] <= 8'hff;
    end
endmodule : flash_array_model
`default_nettype wire

/* testbench/flash_command_sequencer_properties.sv */
// Checker of the flash command sequencer ports.
// Assumes binding into flash_command_sequencer.
`timescale 1ns/10ps
`default_nettype none

module fcs_properties #(
    parameter int unsigned PROG_CYCLES  = 20,
    parameter int unsigned ERASE_CYCLES = 50
) (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        BUS_RD,
    input wire logic [15:0] BUS_ADDR,
    input wire logic [7:0]  BUS_WDATA,
    input wire logic        BUS_RVALID,
    input wire logic [14:0] ARR_ADDR,
    input wire logic [7:0]  ARR_WDATA,
    input wire logic        ARR_WE,
    input wire logic        ARR_SECTOR_ERASE,
    input wire logic [2:0]  ARR_SECTOR,
    input wire logic        ARR_CHIP_ERASE,
    input wire logic        BUSY,
    input wire logic        ID_MODE,
    input wire logic        CMD_ENABLED,
    input wire logic        SECURITY_ACTIVE,
    input wire logic        PARALLEL_LOCK,
    input wire logic        SERIAL_CMD_LOCK
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    int unsigned cnt_q;
    logic        long_q;
    logic        chip_q;
    logic [15:0] addr_q;
    logic [7:0]  data_q;
    // Busy length, kind of running operation, last bus cycle
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cnt_q  <= 0;
            long_q <= 1'b0;
            chip_q <= 1'b0;
        end else begin
            cnt_q <= BUSY ? cnt_q + 1 : 0;
            if (ARR_SECTOR_ERASE || ARR_CHIP_ERASE) long_q <= 1'b1;
            else if (!BUSY) long_q <= 1'b0;
            if (ARR_CHIP_ERASE) chip_q <= 1'b1;
            else if (ARR_WE || ARR_SECTOR_ERASE || $rose(BUSY)) chip_q <= 1'b0;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        addr_q <= BUS_ADDR;
        data_q <= BUS_WDATA;
    end
    ////////////////////////////////////////////////////////////////
    property p_rd; BUS_RD && BUS_ADDR[15] |-> ##2 BUS_RVALID; endproperty
    a_rd: assert property (p_rd) else $error("read answer missing");
    property p_prog; ARR_WE |-> {1'b1, ARR_ADDR} == addr_q && ARR_WDATA == data_q; endproperty
    a_prog: assert property (p_prog) else $error("program target wrong");
    property p_sec; ARR_SECTOR_ERASE |-> ARR_SECTOR == addr_q[14:12] && data_q == 8'h30; endproperty
    a_sec: assert property (p_sec) else $error("sector erase wrong");
    property p_chip; ARR_CHIP_ERASE |-> addr_q[11:0] == 12'h555 && data_q == 8'h10; endproperty
    a_chip: assert property (p_chip) else $error("chip erase wrong");
    property p_start;
        ARR_WE || ARR_SECTOR_ERASE || ARR_CHIP_ERASE |-> BUSY && CMD_ENABLED && !$past(BUSY);
    endproperty
    a_start: assert property (p_start) else $error("operation start wrong");
    property p_short; BUSY && !long_q |-> cnt_q <= PROG_CYCLES + 2; endproperty
    a_short: assert property (p_short) else $error("program too long");
    property p_long; BUSY |-> cnt_q <= ERASE_CYCLES + 2; endproperty
    a_long: assert property (p_long) else $error("erase too long");
    property p_lock; PARALLEL_LOCK || SERIAL_CMD_LOCK |-> SECURITY_ACTIVE && !ARR_WE; endproperty
    a_lock: assert property (p_lock) else $error("lock without security");
    property p_clr; $fell(SECURITY_ACTIVE) |-> chip_q; endproperty
    a_clr: assert property (p_clr) else $error("security cleared wrongly");
    c_prog: cover property (ARR_WE);
    c_chip: cover property (ARR_CHIP_ERASE);
    c_id: cover property ($rose(ID_MODE));
endmodule : fcs_properties

bind flash_command_sequencer fcs_properties #(
    .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) fcs_properties_inst (.*);
`default_nettype wire

/* testbench/test_flash_command_sequencer.sv */
// Self-checking bench of the flash command sequencer with an array model.
// Assumes core/ package and header on the include path.
`timescale 1ns/10ps
`default_nettype none

module test_flash_command_sequencer;
    `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
        $display("ERROR %0t mismatch %h %h", $time, a, b); end end
    logic        clk = 0, rst = 1, bwr = 0, brd = 0, cwr = 0, pm = 0, sm = 0, sst = 0;
    logic [15:0] addr = 0, pa [4];
    logic [7:0]  wdata = 0, key = 0, v, pd [4], a_wd, a_rd, rdata;
    logic [2:0]  fld = 0, sect;
    logic [14:0] a_addr;
    logic        rvalid, a_we, a_re, s_er, c_er, busy, idm, cen, sac, plk, slk;
    int          miscompares = 0, num_checks = 0, seed;
    always #12.5 clk = ~clk;
    flash_command_sequencer #(.PROG_CYCLES(20), .ERASE_CYCLES(50),
        .MAKER_CODE(8'h3c), .FLASH_CODE(8'h5a)) flash_command_sequencer_inst (
        .CLK_SYS(clk), .RST(rst), .BUS_WR(bwr), .BUS_RD(brd), .BUS_ADDR(addr),
        .BUS_WDATA(wdata), .BUS_RDATA(rdata), .BUS_RVALID(rvalid),
        .COMMAND_ENABLE_FIELD(fld), .CONTROL_COMMIT_WR(cwr), .CONTROL_COMMIT_KEY(key),
        .PARALLEL_MODE(pm), .SERIAL_MODE(sm), .SECURITY_STORED(sst), .ARR_ADDR(a_addr),
        .ARR_WDATA(a_wd), .ARR_WE(a_we), .ARR_RE(a_re), .ARR_RDATA(a_rd),
        .ARR_SECTOR_ERASE(s_er), .ARR_SECTOR(sect), .ARR_CHIP_ERASE(c_er), .BUSY(busy),
        .ID_MODE(idm), .CMD_ENABLED(cen), .SECURITY_ACTIVE(sac), .PARALLEL_LOCK(plk),
        .SERIAL_CMD_LOCK(slk));
    flash_array_model flash_array_model_inst (.clk(clk), .we(a_we), .re(a_re),
        .sec_er(s_er), .chip_er(c_er), .sector(sect), .addr(a_addr), .wdata(a_wd),
        .rdata(a_rd));
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        {bwr, addr, wdata} = {1'b1, a, d};
        @(negedge clk);
        bwr = 0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        @(negedge clk);
        {brd, addr} = {1'b1, a};
        @(negedge clk);
        brd = 0;
        repeat (2) @(posedge clk);
        #1 q = rdata;
    endtask : rd
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle
    task automatic cmd3(input logic [7:0] d);
        wr({1'b1, 3'($urandom), 12'h555}, 8'haa);
        wr({1'b1, 3'($urandom), 12'haaa}, 8'h55);
        wr(16'hf555, d);
    endtask : cmd3
    task automatic erase(input logic [15:0] a, input logic [7:0] d);
        cmd3(8'h80);
        wr(16'hf555, 8'haa);
        wr(16'hfaaa, 8'h55);
        wr(a, d);
    endtask : erase
    task automatic commit(input logic [2:0] f, input logic [7:0] k);
        @(negedge clk);
        {fld, key, cwr} = {f, k, 1'b1};
        @(negedge clk);
        cwr = 0;
        settle();
    endtask : commit
    task automatic poll(input logic [15:0] a);
        rd(a, v);
        `CHK(v, 8'hff)
        rd(a, v);
        `CHK(v, 8'hbf)
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
        settle();
        `CHK(busy, 1'b0)
    endtask : poll
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        miscompares++;
        summarize();
    end
    initial begin
        seed = $urandom(32'hbc03);
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 0;
        cmd3(8'ha0);
        wr(16'h8000, 8'h00);
        settle();
        `CHK(busy, 1'b0)
        commit(3'b101, 8'hd4);
        `CHK(cen, 1'b0)
        commit(3'b101, 8'hd5);
        `CHK(cen, 1'b1)
        for (int i = 0; i < 4; i++) begin
            pa[i] = {1'b1, i[2:0], 12'($urandom)};
            pd[i] = 8'($urandom);
            cmd3(8'ha0);
            wr(pa[i], pd[i]);
            if (i == 0) cmd3(8'ha0);
            if (i == 0) wr(16'hfffe, 8'h00);
            poll(pa[i]);
            rd(pa[i], v);
            `CHK(v, pd[i])
        end
        rd(16'hfffe, v);
        `CHK(v, 8'hff)
        wr(16'hf555, 8'haa);
        wr(16'hfaaa, 8'h55);
        wr(16'hf555, 8'h77);
        wr(16'hf555, 8'ha0);
        wr(16'hfffe, 8'h00);
        settle();
        `CHK(busy, 1'b0)
        erase({pa[1][15:12], 12'($urandom)}, 8'h30);
        poll(pa[1]);
        rd(pa[1], v);
        `CHK(v, 8'hff)
        rd(pa[2], v);
        `CHK(v, pd[2])
        for (int s = 0; s < 2; s++) begin
            cmd3(8'h90);
            settle();
            `CHK(idm, 1'b1)
            rd(16'hf000, v);
            `CHK(v, 8'h3c)
            rd(16'hf001, v);
            `CHK(v, 8'h5a)
            rd(16'hff7f, v);
            `CHK(v, s ? 8'h00 : 8'hff)
            wr(16'h9234, 8'hf0);
            settle();
            `CHK(idm, 1'b0)
            rd(pa[2], v);
            `CHK(v, pd[2])
            if (s == 0) cmd3(8'ha5);
            if (s == 0) wr(16'hff7f, 8'h00);
            if (s == 0) poll(pa[2]);
            `CHK(sac, s[0] ? 1'b1 : 1'b1)
        end
        erase({pa[2][15:12], 12'h000}, 8'h30);
        poll(pa[2]);
        `CHK(sac, 1'b1)
        @(negedge clk) pm = 1;
        settle();
        `CHK(plk, 1'b1)
        rd(pa[3], v);
        `CHK(v, 8'h00)
        @(negedge clk) {pm, sm} = 2'b01;
        settle();
        `CHK(slk, 1'b1)
        @(negedge clk) sm = 0;
        settle();
        erase(16'hf555, 8'h10);
        poll(pa[0]);
        `CHK(sac, 1'b0)
        rd(pa[0], v);
        `CHK(v, 8'hff)
        @(negedge clk) pm = 1;
        settle();
        erase(pa[3], 8'h30);
        settle();
        `CHK(busy, 1'b0)
        commit(3'b010, 8'hd5);
        `CHK(cen, 1'b0)
        @(negedge clk) {rst, sst} = 2'b11;
        @(negedge clk) rst = 0;
        settle();
        `CHK(sac, 1'b1)
        `CHK(plk, 1'b1)
        commit(3'b101, 8'hd5);
        erase(16'hf555, 8'h10);
        settle();
        `CHK(busy, 1'b0)
        `CHK(sac, 1'b1)
        summarize();
    end
endmodule : test_flash_command_sequencer
`default_nettype wire
